/* File: coproc_port.sv */
`timescale 1ns/1ns
// Overview of operation
// - Low coprocessor valid freezes the core pipeline.
// - Coprocessor exception taken only at coprocessor instructions.
// - Any hold request freezes pipeline two cycles later, after the synchroniser.
// - One coprocessor launch strobe per decode, never both.
// - One float launch strobe per decode, never both.
// - Absent unit traps on its instructions.
// - Registered coprocessor acknowledge raised on trap taken.
// - Request drops on acknowledge, then acknowledge drops.
// - Low float valid freezes pipeline until raised.
// - Float exception taken only at float instructions.
// - Odd parity over float control return, checked.
// - Flush asserted on every trap; buffers discarded.
// - Fetch strobe pulses on each new fetch made while the pipeline is not frozen.
// - Registered float acknowledge raised on trap taken.
// - Coprocessor codes used only while valid, resolve branches.
module coproc_port (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [1:0] cop_cond_bits_i,
	input wire logic cop_cond_valid_i,
	input wire logic cop_exception_req_i,
	input wire logic cop_stall_req_i,
	input wire logic cop_unit_present_n_i,
	input wire logic [1:0] float_cond_bits_i,
	input wire logic float_cond_valid_i,
	input wire logic float_exception_req_i,
	input wire logic float_stall_req_i,
	input wire logic float_unit_present_n_i,
	input wire logic float_ctrl_parity_i,
	input wire logic fetch_req_i,
	input wire logic decode_valid_i,
	input wire coproc_port_pkg::instr_class_type decode_class_i,
	input wire logic decode_buf_sel_i,
	input wire logic [3:0] branch_mask_i,
	input wire logic ext_trap_i,
	output logic pipe_freeze_o,
	output logic decode_accept_o,
	output logic fetch_strobe_o,
	output logic cop_launch_buf_one_o,
	output logic cop_launch_buf_two_o,
	output logic float_launch_buf_one_o,
	output logic float_launch_buf_two_o,
	output logic cop_exception_ack_o,
	output logic float_exception_ack_o,
	output logic flush_o,
	output logic trap_o,
	output coproc_port_pkg::trap_cause_type trap_cause_o,
	output logic branch_done_o,
	output logic branch_taken_o,
	output logic parity_error_o
);

	////////////////////////////////////////////////////////////////////////////////////
	// Helper functions.

	// Odd parity check: true when the ones count of the word plus its bit is odd.
	function automatic logic parity_ok(input logic [4:0] word, input logic par);
		parity_ok = ^{word, par};
	endfunction : parity_ok

	// Class belongs to the floating-point group.
	function automatic logic is_float(input coproc_port_pkg::instr_class_type cls);
		is_float = (cls == coproc_port_pkg::CLASS_FLOAT_OP) ||
			(cls == coproc_port_pkg::CLASS_FLOAT_BRANCH) ||
			(cls == coproc_port_pkg::CLASS_FLOAT_LDST);
	endfunction : is_float

	// Class belongs to the coprocessor group.
	function automatic logic is_cop(input coproc_port_pkg::instr_class_type cls);
		is_cop = (cls == coproc_port_pkg::CLASS_COP_OP) ||
			(cls == coproc_port_pkg::CLASS_COP_BRANCH) ||
			(cls == coproc_port_pkg::CLASS_COP_LDST);
	endfunction : is_cop

	// Branch outcome from the mask and the condition code value.
	function automatic logic cond_hit(input logic [3:0] mask, input logic [1:0] code);
		cond_hit = mask[code];
	endfunction : cond_hit

	////////////////////////////////////////////////////////////////////////////////////
	// Input synchronisers for all pins from the attached units.

	logic [coproc_port_pkg::BUNDLE_WIDTH-1:0] pins_raw;
	logic [coproc_port_pkg::BUNDLE_WIDTH-1:0] pins_sync;

	assign pins_raw = {
		float_ctrl_parity_i,
		float_unit_present_n_i,
		float_stall_req_i,
		float_exception_req_i,
		float_cond_valid_i,
		float_cond_bits_i,
		cop_unit_present_n_i,
		cop_stall_req_i,
		cop_exception_req_i,
		cop_cond_valid_i,
		cop_cond_bits_i
	};

	pin_sync #(
		.WIDTH(coproc_port_pkg::BUNDLE_WIDTH),
		.STAGES(coproc_port_pkg::SYNC_STAGES),
		.IDLE({
			coproc_port_pkg::PARITY_IDLE,
			coproc_port_pkg::PRESENT_N_IDLE,
			coproc_port_pkg::REQ_IDLE,
			coproc_port_pkg::REQ_IDLE,
			coproc_port_pkg::VALID_IDLE,
			2'h0,
			coproc_port_pkg::PRESENT_N_IDLE,
			coproc_port_pkg::REQ_IDLE,
			coproc_port_pkg::REQ_IDLE,
			coproc_port_pkg::VALID_IDLE,
			2'h0
		})
	) u_pin_sync (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.async_i(pins_raw),
		.sync_o(pins_sync)
	);

	logic [1:0] ccond;
	logic cvalid;
	logic cop_exception_req;
	logic cstall;
	logic cpres_n;
	logic [1:0] fcond;
	logic fvalid;
	logic float_exception_req;
	logic fstall;
	logic fpres_n;
	logic fpar;

	assign ccond = pins_sync[coproc_port_pkg::POS_CCOND +: coproc_port_pkg::COND_WIDTH];
	assign cvalid = pins_sync[coproc_port_pkg::POS_CVALID];
	assign cop_exception_req = pins_sync[coproc_port_pkg::POS_COP_EXCEPTION_REQ];
	assign cstall = pins_sync[coproc_port_pkg::POS_CSTALL];
	assign cpres_n = pins_sync[coproc_port_pkg::POS_CPRES];
	assign fcond = pins_sync[coproc_port_pkg::POS_FCOND +: coproc_port_pkg::COND_WIDTH];
	assign fvalid = pins_sync[coproc_port_pkg::POS_FVALID];
	assign float_exception_req = pins_sync[coproc_port_pkg::POS_FLOAT_EXCEPTION_REQ];
	assign fstall = pins_sync[coproc_port_pkg::POS_FSTALL];
	assign fpres_n = pins_sync[coproc_port_pkg::POS_FPRES];
	assign fpar = pins_sync[coproc_port_pkg::POS_FPAR];

	////////////////////////////////////////////////////////////////////////////////////
	// Pipeline freeze and decode acceptance.

	logic freeze;
	logic accept;

	// Either hold or either invalid condition code freezes decode at once.
	assign freeze = cstall | fstall | ~cvalid | ~fvalid;
	assign accept = decode_valid_i & ~freeze;
	assign pipe_freeze_o = freeze;
	assign decode_accept_o = accept;

	////////////////////////////////////////////////////////////////////////////////////
	// Trap decision for the accepted decode.

	logic par_good;
	logic [4:0] par_word;
	logic float_cls;
	logic cop_cls;
	coproc_port_pkg::trap_cause_type nxt_cause;

	assign par_word = {fcond, fvalid, float_exception_req, fstall};
	assign par_good = parity_ok(par_word, fpar);
	assign float_cls = is_float(decode_class_i);
	assign cop_cls = is_cop(decode_class_i);

	always_comb begin
		nxt_cause = coproc_port_pkg::CAUSE_NONE;
		if (ext_trap_i) begin
			nxt_cause = coproc_port_pkg::CAUSE_EXTERNAL;
		end else if (accept && !par_good) begin
			nxt_cause = coproc_port_pkg::CAUSE_PARITY;
		end else if (accept && float_cls && fpres_n) begin
			nxt_cause = coproc_port_pkg::CAUSE_FLOAT_DISABLED;
		end else if (accept && cop_cls && cpres_n) begin
			nxt_cause = coproc_port_pkg::CAUSE_COP_DISABLED;
		end else if (accept && float_cls && float_exception_req && !float_exception_ack_o) begin
			nxt_cause = coproc_port_pkg::CAUSE_FLOAT_EXC;
		end else if (accept && cop_cls && cop_exception_req && !cop_exception_ack_o) begin
			nxt_cause = coproc_port_pkg::CAUSE_COP_EXC;
		end
	end

	logic take_trap;

	assign take_trap = (nxt_cause != coproc_port_pkg::CAUSE_NONE);

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			trap_o <= coproc_port_pkg::FLAG_RESET;
			flush_o <= coproc_port_pkg::FLAG_RESET;
			trap_cause_o <= coproc_port_pkg::CAUSE_NONE;
			parity_error_o <= coproc_port_pkg::FLAG_RESET;
		end else begin
			trap_o <= take_trap;
			flush_o <= take_trap;
			trap_cause_o <= nxt_cause;
			parity_error_o <= ~par_good;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////
	// Launch strobes and fetch strobe.

	logic launch;

	// No launch strobe goes out with a trap, so the unit never sees one beside flush.
	assign launch = accept & ~take_trap;

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cop_launch_buf_one_o <= coproc_port_pkg::STROBE_RESET;
			cop_launch_buf_two_o <= coproc_port_pkg::STROBE_RESET;
		end else begin
			// A single selector bit means buffer one and two never pulse together.
			cop_launch_buf_one_o <= launch & cop_cls &
				(decode_buf_sel_i == coproc_port_pkg::BUF_SEL_ONE);
			cop_launch_buf_two_o <= launch & cop_cls &
				(decode_buf_sel_i == coproc_port_pkg::BUF_SEL_TWO);
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			float_launch_buf_one_o <= coproc_port_pkg::STROBE_RESET;
			float_launch_buf_two_o <= coproc_port_pkg::STROBE_RESET;
		end else begin
			float_launch_buf_one_o <= launch & float_cls &
				(decode_buf_sel_i == coproc_port_pkg::BUF_SEL_ONE);
			float_launch_buf_two_o <= launch & float_cls &
				(decode_buf_sel_i == coproc_port_pkg::BUF_SEL_TWO);
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			fetch_strobe_o <= coproc_port_pkg::STROBE_RESET;
		end else begin
			fetch_strobe_o <= fetch_req_i & ~freeze;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////
	// Exception acknowledge handshakes.

	coproc_port_pkg::ack_state_type float_ack_ff;
	coproc_port_pkg::ack_state_type cop_ack_ff;

	// Acknowledge stays up until the synchronised request is gone, so it is never taken twice.
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			float_ack_ff <= coproc_port_pkg::ACK_IDLE;
		end else begin
			case (float_ack_ff)
				coproc_port_pkg::ACK_IDLE: begin
					if (nxt_cause == coproc_port_pkg::CAUSE_FLOAT_EXC) begin
						float_ack_ff <= coproc_port_pkg::ACK_RAISED;
					end
				end
				coproc_port_pkg::ACK_RAISED: begin
					if (!float_exception_req) begin
						float_ack_ff <= coproc_port_pkg::ACK_IDLE;
					end
				end
				default: begin
					float_ack_ff <= coproc_port_pkg::ACK_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cop_ack_ff <= coproc_port_pkg::ACK_IDLE;
		end else begin
			case (cop_ack_ff)
				coproc_port_pkg::ACK_IDLE: begin
					if (nxt_cause == coproc_port_pkg::CAUSE_COP_EXC) begin
						cop_ack_ff <= coproc_port_pkg::ACK_RAISED;
					end
				end
				coproc_port_pkg::ACK_RAISED: begin
					if (!cop_exception_req) begin
						cop_ack_ff <= coproc_port_pkg::ACK_IDLE;
					end
				end
				default: begin
					cop_ack_ff <= coproc_port_pkg::ACK_IDLE;
				end
			endcase
		end
	end

	assign float_exception_ack_o = (float_ack_ff == coproc_port_pkg::ACK_RAISED);
	assign cop_exception_ack_o = (cop_ack_ff == coproc_port_pkg::ACK_RAISED);

	////////////////////////////////////////////////////////////////////////////////////
	// Branch resolution.

	logic float_br;
	logic cop_br;

	assign float_br = (decode_class_i == coproc_port_pkg::CLASS_FLOAT_BRANCH);
	assign cop_br = (decode_class_i == coproc_port_pkg::CLASS_COP_BRANCH);

	// Accept waits for both valid inputs, so the codes belong to the last compare.
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			branch_done_o <= coproc_port_pkg::FLAG_RESET;
			branch_taken_o <= coproc_port_pkg::FLAG_RESET;
		end else begin
			branch_done_o <= launch & (float_br | cop_br);
			branch_taken_o <= launch & ((float_br & cond_hit(branch_mask_i, fcond)) |
				(cop_br & cond_hit(branch_mask_i, ccond)));
		end
	end

endmodule : coproc_port

/* File: coproc_port_pkg.sv */
package coproc_port_pkg;

	// Depth of the input synchroniser chain.
	localparam int SYNC_STAGES = 2;

	// Width of a condition code field.
	localparam int COND_WIDTH = 2;

	// Width of the branch condition mask: one bit per condition code value.
	localparam int MASK_WIDTH = 4;

	// Buffer selector encoding for the launch strobes.
	localparam logic BUF_SEL_ONE = 1'h0;
	localparam logic BUF_SEL_TWO = 1'h1;

	// Reset values of the registered outputs.
	localparam logic STROBE_RESET = 1'h0;
	localparam logic ACK_RESET = 1'h0;
	localparam logic FLAG_RESET = 1'h0;

	// Idle levels the synchronisers hold under reset.
	localparam logic VALID_IDLE = 1'h1;
	localparam logic REQ_IDLE = 1'h0;
	localparam logic PRESENT_N_IDLE = 1'h1;
	localparam logic PARITY_IDLE = 1'h0;

	// Bit positions inside the synchronised input bundle.
	localparam int POS_CCOND = 0;
	localparam int POS_CVALID = 2;
	localparam int POS_COP_EXCEPTION_REQ = 3;
	localparam int POS_CSTALL = 4;
	localparam int POS_CPRES = 5;
	localparam int POS_FCOND = 6;
	localparam int POS_FVALID = 8;
	localparam int POS_FLOAT_EXCEPTION_REQ = 9;
	localparam int POS_FSTALL = 10;
	localparam int POS_FPRES = 11;
	localparam int POS_FPAR = 12;
	localparam int BUNDLE_WIDTH = 13;

	// Class of the instruction standing in the decode stage.
	typedef enum logic [2:0] {
		CLASS_OTHER,
		CLASS_FLOAT_OP,
		CLASS_FLOAT_BRANCH,
		CLASS_FLOAT_LDST,
		CLASS_COP_OP,
		CLASS_COP_BRANCH,
		CLASS_COP_LDST
	} instr_class_type;

	// Cause reported with a trap.
	typedef enum logic [2:0] {
		CAUSE_NONE,
		CAUSE_FLOAT_DISABLED,
		CAUSE_COP_DISABLED,
		CAUSE_FLOAT_EXC,
		CAUSE_COP_EXC,
		CAUSE_PARITY,
		CAUSE_EXTERNAL
	} trap_cause_type;

	// Acknowledge handshake state for one attached unit.
	typedef enum logic {
		ACK_IDLE,
		ACK_RAISED
	} ack_state_type;

endpackage : coproc_port_pkg

/* File: coproc_port_sva.sv */
`timescale 1ns/1ns
module coproc_port_sva (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic cop_exception_req_i,
	input wire logic cop_stall_req_i,
	input wire logic float_cond_valid_i,
	input wire logic float_exception_req_i,
	input wire logic float_stall_req_i,
	input wire logic float_unit_present_n_i,
	input wire logic pipe_freeze_o,
	input wire logic cop_launch_buf_one_o,
	input wire logic cop_launch_buf_two_o,
	input wire logic float_launch_buf_one_o,
	input wire logic float_launch_buf_two_o,
	input wire logic cop_exception_ack_o,
	input wire logic float_exception_ack_o,
	input wire logic flush_o,
	input wire logic trap_o,
	input wire coproc_port_pkg::trap_cause_type trap_cause_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);
	a_cop_launch_excl: assert property (!(cop_launch_buf_one_o && cop_launch_buf_two_o))
		else $error("both coprocessor launch strobes high");
	a_float_launch_excl: assert property (!(float_launch_buf_one_o && float_launch_buf_two_o))
		else $error("both float launch strobes high");
	a_hold_freeze: assert property ($rose(float_stall_req_i || cop_stall_req_i) |-> ##[0:4] pipe_freeze_o)
		else $error("hold did not freeze pipeline");
	a_valid_freeze: assert property ($fell(float_cond_valid_i) |-> ##[0:4] pipe_freeze_o)
		else $error("low float valid did not freeze pipeline");
	a_trap_flush: assert property (trap_o |-> ##[0:1] flush_o)
		else $error("trap without flush");
	a_float_ack_drop: assert property (!float_exception_req_i [*6] |-> !float_exception_ack_o)
		else $error("float acknowledge stayed after request dropped");
	a_cop_ack_drop: assert property (!cop_exception_req_i [*6] |-> !cop_exception_ack_o)
		else $error("coprocessor acknowledge stayed after request dropped");
	a_absent_trap: assert property (trap_o && trap_cause_o == coproc_port_pkg::CAUSE_FLOAT_DISABLED
		|-> float_unit_present_n_i)
		else $error("unit disabled trap while unit present");
	a_launch_noflush: assert property (flush_o |-> !(cop_launch_buf_one_o ||
		cop_launch_buf_two_o || float_launch_buf_one_o || float_launch_buf_two_o))
		else $error("launch strobe beside flush");
	cover property (float_exception_ack_o);
	cover property (cop_exception_ack_o);
	cover property (trap_o && flush_o);
endmodule : coproc_port_sva
bind coproc_port coproc_port_sva coproc_port_sva_i (.mclk_i(mclk_i), .rst_i(rst_i),
	.cop_exception_req_i(cop_exception_req_i), .cop_stall_req_i(cop_stall_req_i),
	.float_cond_valid_i(float_cond_valid_i), .float_exception_req_i(float_exception_req_i),
	.float_stall_req_i(float_stall_req_i), .float_unit_present_n_i(float_unit_present_n_i),
	.pipe_freeze_o(pipe_freeze_o), .cop_launch_buf_one_o(cop_launch_buf_one_o),
	.cop_launch_buf_two_o(cop_launch_buf_two_o), .float_launch_buf_one_o(float_launch_buf_one_o),
	.float_launch_buf_two_o(float_launch_buf_two_o), .cop_exception_ack_o(cop_exception_ack_o),
	.float_exception_ack_o(float_exception_ack_o), .flush_o(flush_o), .trap_o(trap_o),
	.trap_cause_o(trap_cause_o));

/* File: pin_sync.sv */
`timescale 1ns/1ns
module pin_sync #(
	parameter int WIDTH = 1,
	parameter int STAGES = coproc_port_pkg::SYNC_STAGES,
	parameter logic [WIDTH-1:0] IDLE = '0
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	// Chain of flip-flops; only the last stage is read outside.
	logic [WIDTH-1:0] chain_ff [STAGES];

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < STAGES; i++) begin
				chain_ff[i] <= IDLE;
			end
		end else begin
			chain_ff[0] <= async_i;
			for (int i = 1; i < STAGES; i++) begin
				chain_ff[i] <= chain_ff[i-1];
			end
		end
	end

	assign sync_o = chain_ff[STAGES-1];

endmodule : pin_sync

/* File: tb_coproc_port.sv */
`timescale 1ns/1ns
module tb_coproc_port;
	logic mclk_i = 1'h0;
	logic rst_i = 1'h1;
	logic [3:0] fcmd = 4'h0;
	logic [3:0] ccmd = 4'h0;
	logic fpres_n = 1'h0;
	logic cpres_n = 1'h0;
	logic dvalid = 1'h0;
	logic dsel = 1'h0;
	coproc_port_pkg::instr_class_type dclass = coproc_port_pkg::CLASS_OTHER;
	coproc_port_pkg::trap_cause_type tcause, cause;
	logic [1:0] fcond, ccond;
	logic fvalid, cvalid, float_exception_req, cop_exception_req, fstall, cstall, fpar;
	logic frz, acc, cl1, cl2, fl1, fl2, cack, fack, flush, trap, perr;
	logic [8:0] seen = 9'h0;
	logic [3:0] bmask = 4'h0;
	logic xtrap = 1'h0;
	logic fstb, bdone, btaken;
	logic [7:0] ndone = 8'h0, ntaken = 8'h0, nfetch = 8'h0;
	int miscompares = 0;
	int checks = 0;
	always #25 mclk_i = ~mclk_i;
	unit_model unit_model_i (.mclk_i(mclk_i), .rst_i(rst_i), .compare_i(fcmd[0]), .stall_i(fcmd[1]),
		.fault_i(fcmd[2]), .flip_i(fcmd[3]), .ack_i(fack), .cond_o(fcond), .valid_o(fvalid),
		.exc_o(float_exception_req), .stall_o(fstall), .parity_o(fpar));
	unit_model unit_model_c_i (.mclk_i(mclk_i), .rst_i(rst_i), .compare_i(ccmd[0]), .stall_i(ccmd[1]),
		.fault_i(ccmd[2]), .flip_i(ccmd[3]), .ack_i(cack), .cond_o(ccond), .valid_o(cvalid),
		.exc_o(cop_exception_req), .stall_o(cstall), .parity_o());
	coproc_port coproc_port_i (.mclk_i(mclk_i), .rst_i(rst_i), .cop_cond_bits_i(ccond),
		.cop_cond_valid_i(cvalid), .cop_exception_req_i(cop_exception_req), .cop_stall_req_i(cstall),
		.cop_unit_present_n_i(cpres_n), .float_cond_bits_i(fcond), .float_cond_valid_i(fvalid),
		.float_exception_req_i(float_exception_req), .float_stall_req_i(fstall), .float_unit_present_n_i(fpres_n),
		.float_ctrl_parity_i(fpar), .fetch_req_i(dvalid), .decode_valid_i(dvalid),
		.decode_class_i(dclass), .decode_buf_sel_i(dsel), .branch_mask_i(bmask), .ext_trap_i(xtrap),
		.pipe_freeze_o(frz), .decode_accept_o(acc), .fetch_strobe_o(fstb), .cop_launch_buf_one_o(cl1),
		.cop_launch_buf_two_o(cl2), .float_launch_buf_one_o(fl1), .float_launch_buf_two_o(fl2),
		.cop_exception_ack_o(cack), .float_exception_ack_o(fack), .flush_o(flush), .trap_o(trap),
		.trap_cause_o(tcause), .branch_done_o(bdone), .branch_taken_o(btaken), .parity_error_o(perr));
	always @(posedge mclk_i) begin
		seen <= seen | {perr, fack, cack, flush, frz, fl2, fl1, cl2, cl1};
		if (trap) cause <= tcause;
		ndone <= ndone + {7'h0, bdone};
		ntaken <= ntaken + {7'h0, bdone & btaken};
		nfetch <= nfetch + {7'h0, fstb};
	end
	task automatic check(input logic [8:0] got, input logic [8:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : check
	task automatic run(input int n);
		repeat (n) @(negedge mclk_i);
	endtask : run
	task automatic conclude();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : conclude
	task automatic issue(input coproc_port_pkg::instr_class_type c, input logic s);
		int k;
		dclass = c;
		dsel = s;
		dvalid = 1'h1;
		for (k = 0; k < 20; k++) begin
			#1;
			if (acc === 1'h1 || trap === 1'h1) break;
			run(1);
		end
		run(1);
		dvalid = 1'h0;
		if (k == 20) begin
			miscompares++;
			conclude();
		end
	endtask : issue
	task automatic t_launch();
		int i;
		for (i = 0; i < 4; i++) begin
			seen = 9'h0;
			issue(i[1] ? coproc_port_pkg::CLASS_COP_OP : coproc_port_pkg::CLASS_FLOAT_OP, i[0]);
			run(6);
			check({seen[8], seen[3:0]}, {1'h0, 4'h1 << (i[0] + (i[1] ? 0 : 2))});
		end
		$display("launch test done");
	endtask : t_launch
	task automatic t_hold();
		int k;
		for (k = 0; k < 4; k++) begin
			seen = 9'h0;
			{ccmd[1:0], fcmd[1:0]} = 4'h1 << k;
			run(1);
			{ccmd[1:0], fcmd[1:0]} = 4'h0;
			run(6);
			check(seen[4], 1'h1);
			run(8);
			seen = 9'h0;
			run(4);
			check(seen[4], 1'h0);
		end
		$display("hold test done");
	endtask : t_hold
	task automatic t_exc();
		int u;
		for (u = 0; u < 2; u++) begin
			seen = 9'h0;
			fcmd[2] = (u == 0);
			ccmd[2] = (u == 1);
			run(1);
			fcmd[2] = 1'h0;
			ccmd[2] = 1'h0;
			issue(coproc_port_pkg::CLASS_OTHER, 1'h0);
			run(8);
			check(seen[7:5], 3'h0);
			issue(u == 0 ? coproc_port_pkg::CLASS_FLOAT_OP : coproc_port_pkg::CLASS_COP_OP, 1'h0);
			run(8);
			check(seen[7:5], u == 0 ? 3'h5 : 3'h3);
			check(cause, u == 0 ? coproc_port_pkg::CAUSE_FLOAT_EXC : coproc_port_pkg::CAUSE_COP_EXC);
			run(10);
			check({cack, fack}, 2'h0);
		end
		$display("exception test done");
	endtask : t_exc
	task automatic t_absent();
		int u;
		for (u = 0; u < 2; u++) begin
			seen = 9'h0;
			fpres_n = (u == 0);
			cpres_n = (u == 1);
			run(4);
			issue(u == 0 ? coproc_port_pkg::CLASS_FLOAT_LDST : coproc_port_pkg::CLASS_COP_BRANCH, 1'h0);
			run(6);
			check(seen[5], 1'h1);
			check(cause, u == 0 ? coproc_port_pkg::CAUSE_FLOAT_DISABLED : coproc_port_pkg::CAUSE_COP_DISABLED);
			fpres_n = 1'h0;
			cpres_n = 1'h0;
			run(4);
		end
		$display("absent unit test done");
	endtask : t_absent
	task automatic t_parity();
		seen = 9'h0;
		fcmd[3] = 1'h1;
		run(1);
		fcmd[3] = 1'h0;
		run(6);
		check(seen[8], 1'h1);
		fcmd[3] = 1'h1;
		run(3);
		issue(coproc_port_pkg::CLASS_OTHER, 1'h0);
		fcmd[3] = 1'h0;
		run(6);
		check(cause, coproc_port_pkg::CAUSE_PARITY);
		$display("parity test done");
	endtask : t_parity
	task automatic t_branch();
		int u, m;
		coproc_port_pkg::instr_class_type bcls;
		for (u = 0; u < 2; u++) begin
			{ndone, ntaken, nfetch} = 24'h0;
			bcls = (u == 0) ? coproc_port_pkg::CLASS_FLOAT_BRANCH :
				coproc_port_pkg::CLASS_COP_BRANCH;
			for (m = 0; m < 4; m++) begin
				bmask = 4'h1 << m;
				issue(bcls, 1'h0);
				run(3);
			end
			check({ntaken[3:0], ndone[3:0]}, 8'h14);
			check(nfetch, 8'h4);
		end
		seen = 9'h0;
		xtrap = 1'h1;
		run(1);
		xtrap = 1'h0;
		run(4);
		check(seen[5], 1'h1);
		check(cause, coproc_port_pkg::CAUSE_EXTERNAL);
		$display("branch test done");
	endtask : t_branch
	initial begin
		run(2);
		rst_i = 1'h0;
		run(2);
		t_launch();
		t_hold();
		t_exc();
		t_absent();
		t_branch();
		t_parity();
		conclude();
	end
endmodule : tb_coproc_port

/* File: unit_model.sv */
`timescale 1ns/1ns
module unit_model (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic compare_i,
	input wire logic stall_i,
	input wire logic fault_i,
	input wire logic flip_i,
	input wire logic ack_i,
	output logic [1:0] cond_o,
	output logic valid_o,
	output logic exc_o,
	output logic stall_o,
	output logic parity_o
);
	logic [2:0] busy_ff;
	// Compare queue: valid drops at once and returns with a fresh code.
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			busy_ff <= 3'h0;
			cond_o <= 2'h0;
		end else if (compare_i) begin
			busy_ff <= 3'h4;
		end else if (busy_ff != 3'h0) begin
			busy_ff <= busy_ff - 3'h1;
			if (busy_ff == 3'h1) begin
				cond_o <= cond_o + 2'h1;
			end
		end
	end
	assign valid_o = (busy_ff == 3'h0);
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			exc_o <= 1'h0;
			stall_o <= 1'h0;
		end else begin
			exc_o <= (exc_o | fault_i) & ~ack_i;
			stall_o <= stall_i & ~exc_o;
		end
	end
	assign parity_o = ~^{cond_o, valid_o, exc_o, stall_o} ^ flip_i;
endmodule : unit_model
